/* hdl/hists_core.v */
// Host interrupt indication: event timestamp, product identifier and
// interrupt status with the host interrupt line.
// Assumes FIFO events, channel reads, time base and register strobes
// all come from logic on core_clk.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
`include "hists_defs.vh"

// Notes on behaviour
// - A 40-bit timestamp area at 0x26-0x2A records the interrupt time or the event request time.
// - With the event-time select clear, the area takes the time of the first line-raising event, two cycles before the interrupt line rises.
// - The timestamp is loaded first, then the status register, then the interrupt line rises.
// - With the event-time select set, the interrupt time is only given on the parameter port.
// - A read-only 8-bit product identifier sits at 0x2B with a fixed value.
// - A status register at 0x2D shows a polling host which of the three channels holds data.
// - Masks gate the asserted bit, the line and the timestamp capture, never the channel status bits.
// - A nonzero status value means an interrupt is pending, zero means none.
// - Reading one channel clears only that channel's status bits.
// - The asserted bit and the line stay high until every unmasked pending source is retrieved.
// - Status bit 0 mirrors the interrupt line level.
// - Status bits 1-2 give the wake-up FIFO cause: none, immediate, latency, watermark.
// - Status bits 3-4 give the non-wake-up FIFO cause with the same four codes.
// - Status bit 5 shows a command result in the status FIFO in synchronous mode.
// - Status bit 6 shows debug data or async responses, including command answers in async mode.
module hists_core #(
   parameter [7:0] PRODUCT_ID_VAL = 8'h5A // Arbitrary identity value
) (
   core_clk,
   resetn,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata_q,
   sys_time,
   host_event_req,
   wake_evt,
   wake_cause,
   nwake_evt,
   nwake_cause,
   sd_resp_evt,
   sd_debug_evt,
   rd_wake_chan,
   rd_nwake_chan,
   rd_status_chan,
   host_irq_out_q,
   irq_time_param_q,
   ctrl_q
);
   input  wire                   core_clk;
   input  wire                   resetn;
   input  wire [7:0]             reg_addr;
   input  wire [7:0]             reg_wdata;
   input  wire                   reg_wr;
   input  wire                   reg_rd;
   output reg  [7:0]             reg_rdata_q;
   input  wire [`HISTS_TS_W-1:0] sys_time;
   input  wire                   host_event_req;
   input  wire                   wake_evt;
   input  wire [1:0]             wake_cause;
   input  wire                   nwake_evt;
   input  wire [1:0]             nwake_cause;
   input  wire                   sd_resp_evt;
   input  wire                   sd_debug_evt;
   input  wire                   rd_wake_chan;
   input  wire                   rd_nwake_chan;
   input  wire                   rd_status_chan;
   output reg                    host_irq_out_q;
   output reg  [`HISTS_TS_W-1:0] irq_time_param_q;
   output reg  [7:0]             ctrl_q;

   reg  [7:0]             ctrl_d;
   reg  [`HISTS_TS_W-1:0] ts_area_q;
   reg  [`HISTS_TS_W-1:0] ts_area_d;
   reg  [`HISTS_TS_W-1:0] irq_time_param_d;

   // Stage between timestamp load and status update
   reg        wake_stg_q;
   reg [1:0]  wake_cause_stg_q;
   reg        nwake_stg_q;
   reg [1:0]  nwake_cause_stg_q;
   reg        sd_res_stg_q;
   reg        sd_dbg_stg_q;

   reg        sd_result_q;
   reg        sd_result_d;
   reg        sd_debug_q;
   reg        sd_debug_d;
   reg        cap_hold_q;
   reg        cap_hold_d;
   reg        host_irq_out_d;
   reg [7:0]  reg_rdata_d;

   wire [1:0] fld_q [0:1];
   wire [1:0] stg_evt;
   wire [3:0] stg_cause;
   wire [1:0] chan_rd;
   wire       mask_wake;
   wire       mask_nwake;
   wire       ts_evt_sel;
   wire       async_mode;
   wire       wake_go;
   wire       nwake_go;
   wire       ctrl_wr_hit;
   wire       evt_any;
   wire       stage_busy;
   wire       cap_now;
   wire       unmasked_pending;
   wire [7:0] status_val;

   assign mask_wake  = ctrl_q[`HISTS_CTRL_MASK_WAKE];
   assign mask_nwake = ctrl_q[`HISTS_CTRL_MASK_NWAKE];
   assign ts_evt_sel = ctrl_q[`HISTS_CTRL_TS_EVT_SEL];
   assign async_mode = ctrl_q[`HISTS_CTRL_ASYNC];

   assign stg_evt   = {nwake_stg_q, wake_stg_q};
   assign stg_cause = {nwake_cause_stg_q, wake_cause_stg_q};
   assign chan_rd   = {rd_nwake_chan, rd_wake_chan};

   // Per-FIFO cause fields
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_fifo
         hists_cause u_cause (
            .core_clk  (core_clk),
            .resetn    (resetn),
            .set_evt   (stg_evt[gi]),
            .set_cause (stg_cause[2*gi+1:2*gi]),
            .clr_read  (chan_rd[gi]),
            .field_q   (fld_q[gi])
         );
      end
   endgenerate

   // Only events that can raise the line open an episode
   assign wake_go     = wake_evt & (wake_cause != `HISTS_CAUSE_NONE) & ~mask_wake;
   assign nwake_go    = nwake_evt & (nwake_cause != `HISTS_CAUSE_NONE) & ~mask_nwake;
   assign ctrl_wr_hit = reg_wr & (reg_addr == `HISTS_OFF_CTRL);
   assign evt_any     = wake_go | nwake_go | sd_resp_evt | sd_debug_evt;
   assign stage_busy = wake_stg_q | nwake_stg_q | sd_res_stg_q | sd_dbg_stg_q;

   // First event while the line is low marks the assertion time
   assign cap_now = evt_any & ~host_irq_out_q & ~cap_hold_q;

   // Masks act on the line and on timestamp capture; status flags are never masked
   assign unmasked_pending = ((fld_q[0] != `HISTS_CAUSE_NONE) & ~mask_wake)
                           | ((fld_q[1] != `HISTS_CAUSE_NONE) & ~mask_nwake)
                           | sd_result_q | sd_debug_q;

   // Status image; any set bit means a pending source
   assign status_val = {1'b0, sd_debug_q, sd_result_q, fld_q[1], fld_q[0],
                        host_irq_out_q};

   // Control register
   always @* begin
      ctrl_d = ctrl_q;
      if (ctrl_wr_hit) begin
         ctrl_d = reg_wdata & `HISTS_CTRL_WMASK;
      end
   end

   // Timestamp area and parameter copy
   always @* begin
      ts_area_d        = ts_area_q;
      irq_time_param_d = irq_time_param_q;
      if (cap_now) begin
         irq_time_param_d = sys_time;
         if (!ts_evt_sel) begin
            ts_area_d = sys_time;
         end
      end
      if (ts_evt_sel && host_event_req) begin
         ts_area_d = sys_time;
      end
   end

   // Hold off recapture until the interrupt episode ends
   always @* begin
      cap_hold_d = (cap_hold_q | cap_now) & (host_irq_out_q | stage_busy | cap_now
                   | unmasked_pending);
   end

   // Status FIFO flags; a new event wins over a same-cycle read clear
   always @* begin
      sd_result_d = sd_result_q;
      sd_debug_d  = sd_debug_q;
      if (rd_status_chan) begin
         sd_result_d = 1'b0;
         sd_debug_d  = 1'b0;
      end
      if (sd_res_stg_q) begin
         sd_result_d = 1'b1;
      end
      if (sd_dbg_stg_q) begin
         sd_debug_d = 1'b1;
      end
   end

   // Line follows the status register one cycle later
   always @* begin
      host_irq_out_d = unmasked_pending;
   end

   // Register read mux
   always @* begin
      reg_rdata_d = `HISTS_BYTE_RESET;
      if (reg_rd) begin
         case (reg_addr)
            `HISTS_OFF_CTRL:    reg_rdata_d = ctrl_q;
            `HISTS_OFF_TS0:     reg_rdata_d = ts_area_q[7:0];
            `HISTS_OFF_TS1:     reg_rdata_d = ts_area_q[15:8];
            `HISTS_OFF_TS2:     reg_rdata_d = ts_area_q[23:16];
            `HISTS_OFF_TS3:     reg_rdata_d = ts_area_q[31:24];
            `HISTS_OFF_TS4:     reg_rdata_d = ts_area_q[39:32];
            `HISTS_OFF_PROD_ID: reg_rdata_d = PRODUCT_ID_VAL;
            `HISTS_OFF_STATUS:  reg_rdata_d = status_val;
            default:            reg_rdata_d = `HISTS_BYTE_RESET;
         endcase
      end
   end

   // Wake-up FIFO stage: timestamp loads on the edge that takes the event
   always @(posedge core_clk) begin
      if (!resetn) begin
         wake_stg_q       <= 1'b0;
         wake_cause_stg_q <= `HISTS_CAUSE_NONE;
      end else begin
         wake_stg_q       <= wake_evt & (wake_cause != `HISTS_CAUSE_NONE);
         wake_cause_stg_q <= wake_cause;
      end
   end

   // Non-wake-up FIFO stage
   always @(posedge core_clk) begin
      if (!resetn) begin
         nwake_stg_q       <= 1'b0;
         nwake_cause_stg_q <= `HISTS_CAUSE_NONE;
      end else begin
         nwake_stg_q       <= nwake_evt & (nwake_cause != `HISTS_CAUSE_NONE);
         nwake_cause_stg_q <= nwake_cause;
      end
   end

   // Status and debug FIFO stage
   always @(posedge core_clk) begin
      if (!resetn) begin
         sd_res_stg_q <= 1'b0;
         sd_dbg_stg_q <= 1'b0;
      end else begin
         sd_res_stg_q <= sd_resp_evt & ~async_mode;
         sd_dbg_stg_q <= sd_debug_evt | (sd_resp_evt & async_mode);
      end
   end

   // Control register state
   always @(posedge core_clk) begin
      if (!resetn) begin
         ctrl_q <= `HISTS_CTRL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // Timestamp area and parameter copy state
   always @(posedge core_clk) begin
      if (!resetn) begin
         ts_area_q        <= `HISTS_TS_RESET;
         irq_time_param_q <= `HISTS_TS_RESET;
      end else begin
         ts_area_q        <= ts_area_d;
         irq_time_param_q <= irq_time_param_d;
      end
   end

   // Status FIFO flag state
   always @(posedge core_clk) begin
      if (!resetn) begin
         sd_result_q <= 1'b0;
         sd_debug_q  <= 1'b0;
      end else begin
         sd_result_q <= sd_result_d;
         sd_debug_q  <= sd_debug_d;
      end
   end

   // Episode hold and interrupt line
   always @(posedge core_clk) begin
      if (!resetn) begin
         cap_hold_q     <= 1'b0;
         host_irq_out_q <= 1'b0;
      end else begin
         cap_hold_q     <= cap_hold_d;
         host_irq_out_q <= host_irq_out_d;
      end
   end

   // Read data
   always @(posedge core_clk) begin
      if (!resetn) begin
         reg_rdata_q <= `HISTS_BYTE_RESET;
      end else begin
         reg_rdata_q <= reg_rdata_d;
      end
   end

endmodule // hists_core

/* shared/hists_defs.vh */
// Constants of the host interrupt status and timestamp block.
// Assumes an 8-bit register port with byte addresses as printed.
`ifndef HISTS_DEFS_VH
`define HISTS_DEFS_VH

// Register offsets
`define HISTS_OFF_CTRL        8'h06
`define HISTS_OFF_TS0         8'h26
`define HISTS_OFF_TS1         8'h27
`define HISTS_OFF_TS2         8'h28
`define HISTS_OFF_TS3         8'h29
`define HISTS_OFF_TS4         8'h2A
`define HISTS_OFF_PROD_ID     8'h2B
`define HISTS_OFF_STATUS      8'h2D

// Control register fields
`define HISTS_CTRL_MASK_WAKE  0
`define HISTS_CTRL_MASK_NWAKE 1
`define HISTS_CTRL_TS_EVT_SEL 2
`define HISTS_CTRL_ASYNC      3
`define HISTS_CTRL_WMASK      8'h0F
`define HISTS_CTRL_RESET      8'h00

// Status register fields
`define HISTS_ST_IRQ          0
`define HISTS_ST_WAKE_LO      1
`define HISTS_ST_NWAKE_LO     3
`define HISTS_ST_SD_RESULT    5
`define HISTS_ST_SD_DEBUG     6

// Cause codes
`define HISTS_CAUSE_NONE      2'h0
`define HISTS_CAUSE_IMMED     2'h1
`define HISTS_CAUSE_LATENCY   2'h2
`define HISTS_CAUSE_WMARK     2'h3

// Widths and reset values
`define HISTS_TS_W            40
`define HISTS_TS_RESET        40'h00_0000_0000
`define HISTS_BYTE_RESET      8'h00

`endif

/* hdl/hists_cause.v */
// Holds one FIFO's two-bit interrupt cause field.
// Assumes set and clear pulses come from logic on the same clock.
`timescale 1ns/1ns
`include "hists_defs.vh"

module hists_cause (
   core_clk,
   resetn,
   set_evt,
   set_cause,
   clr_read,
   field_q
);
   input  wire       core_clk;
   input  wire       resetn;
   input  wire       set_evt;
   input  wire [1:0] set_cause;
   input  wire       clr_read;
   output reg  [1:0] field_q;

   reg [1:0] field_d;

   // Strongest cause is kept; a new cause wins over a same-cycle read clear
   always @* begin
      field_d = field_q;
      if (set_evt) begin
         if (clr_read || (set_cause > field_q)) begin
            field_d = set_cause;
         end
      end else if (clr_read) begin
         field_d = `HISTS_CAUSE_NONE;
      end
   end

   always @(posedge core_clk) begin
      if (!resetn) begin
         field_q <= `HISTS_CAUSE_NONE;
      end else begin
         field_q <= field_d;
      end
   end

endmodule // hists_cause

/* sim/hists_core_sva.sv */
// Checker for hists_core: bus answers, status image, line hold, control.
// Assumes single core_clk domain; bound from the bench top file.
`timescale 1ns/1ns
module hists_core_chk #(
   parameter [7:0] PRODUCT_ID_VAL = 8'h5A
) (
   input wire        core_clk,
   input wire        resetn,
   input wire [7:0]  reg_addr,
   input wire [7:0]  reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [7:0]  reg_rdata_q,
   input wire        wake_evt,
   input wire [1:0]  wake_cause,
   input wire        rd_wake_chan,
   input wire        rd_nwake_chan,
   input wire        rd_status_chan,
   input wire        host_irq_out_q,
   input wire [39:0] irq_time_param_q,
   input wire [7:0]  ctrl_q
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   wire rd_any  = rd_wake_chan | rd_nwake_chan | rd_status_chan;
   wire ctrl_wr = reg_wr && reg_addr == 8'h06;
   sequence s_rd(a);
      reg_rd && reg_addr == a ##1 1'b1;
   endsequence
   sequence s_wake;
      wake_evt && wake_cause != 2'h0 && !ctrl_q[0] && !ctrl_wr ##1 !ctrl_wr;
   endsequence
   sequence s_quiet;
      !rd_any && !reg_wr ##1 host_irq_out_q && !rd_any && !reg_wr;
   endsequence
   AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
      else $error("read data not idle");
   AST_PID: assert property (s_rd(8'h2B) |-> reg_rdata_q == PRODUCT_ID_VAL)
      else $error("identifier wrong");
   AST_BIT0: assert property (s_rd(8'h2D) |-> reg_rdata_q[0] == $past(host_irq_out_q))
      else $error("status bit0 differs from line");
   AST_RISE: assert property (s_wake |-> ##[1:2] host_irq_out_q)
      else $error("line did not rise");
   AST_TS_FIRST: assert property ($rose(host_irq_out_q) |-> $stable(irq_time_param_q))
      else $error("time captured with line");
   AST_HOLD: assert property (s_quiet |=> host_irq_out_q)
      else $error("line dropped");
   AST_WR_CTRL: assert property (ctrl_wr |=> ctrl_q == ($past(reg_wdata) & 8'h0F))
      else $error("control write wrong");
   AST_CTRL_HOLD: assert property (!ctrl_wr |=> $stable(ctrl_q))
      else $error("control changed");
endmodule // hists_core_chk

/* sim/hists_host.sv */
// Host model: register strobes, read data taken after the read edge.
// Assumes the device never stalls the bus.
`timescale 1ns/1ns
module hists_host (
   input  wire       core_clk,
   input  wire [7:0] reg_rdata_q,
   output reg  [7:0] reg_addr,
   output reg  [7:0] reg_wdata,
   output reg        reg_wr,
   output reg        reg_rd
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task automatic cyc(input bit w, input [7:0] a, input [7:0] d, output [7:0] q);
      @(posedge core_clk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~a;  // Released bus shows no stale value
      reg_wdata <= ~d;
      @(posedge core_clk);
      q = reg_rdata_q;
   endtask
endmodule // hists_host

/* sim/hists_core_tb.sv */
// Bench for hists_core: events, channel reads, status and timestamp reads.
// Assumes the host model in hists_host.sv and the checker bound below.
`timescale 1ns/1ns
module hists_core_tb;
   localparam [7:0] PID = 8'hA6; // Arbitrary identity value
   reg         core_clk, resetn;
   reg  [7:0]  pl, q;
   reg  [1:0]  wake_cause, nwake_cause, w, n;
   reg  [39:0] sys_time, t, t2, v;
   reg  [31:0] lfsr;
   integer     i, n_fail, checks_done;
   wire [7:0]  reg_addr, reg_wdata, reg_rdata_q, ctrl_q;
   wire        reg_wr, reg_rd, host_irq_out_q;
   wire [39:0] irq_time_param_q;
   hists_core #(.PRODUCT_ID_VAL(PID)) hists_core_inst (.core_clk(core_clk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q), .sys_time(sys_time), .host_event_req(pl[4]),
      .wake_evt(pl[0]), .wake_cause(wake_cause), .nwake_evt(pl[1]), .nwake_cause(nwake_cause),
      .sd_resp_evt(pl[2]), .sd_debug_evt(pl[3]), .rd_wake_chan(pl[5]), .rd_nwake_chan(pl[6]),
      .rd_status_chan(pl[7]), .host_irq_out_q(host_irq_out_q),
      .irq_time_param_q(irq_time_param_q), .ctrl_q(ctrl_q));
   hists_host hists_host_inst (.core_clk(core_clk), .reg_rdata_q(reg_rdata_q),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   always @(posedge core_clk) sys_time <= sys_time + 40'h1;
   function [31:0] nxt(input [31:0] s);
      nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function [7:0] stv(input b0, input [1:0] wc, input [1:0] nc, input b5, input b6);
      stv = {1'b0, b6, b5, nc, wc, b0};
   endfunction
   task chk(input [39:0] seen, input [39:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task rr(input [7:0] a);
      hists_host_inst.cyc(1'b0, a, 8'h00, q);
   endtask
   task wr(input [7:0] a, input [7:0] d);
      hists_host_inst.cyc(1'b1, a, d, q);
   endtask
   task fire(input [7:0] m, output [39:0] tt);
      @(posedge core_clk);
      pl <= m;
      @(posedge core_clk);
      tt = sys_time;
      pl <= 8'h00;
      repeat (4) @(posedge core_clk);
      #1;
   endtask
   task st(input [7:0] e);
      rr(8'h2D);
      chk(q, e);
   endtask
   task ts(input [39:0] e);
      for (i = 0; i < 5; i = i + 1) begin
         rr(8'h26 + i[7:0]);
         v[i*8 +: 8] = q;
      end
      chk(v, e);
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #200000;
      n_fail = n_fail + 1;
      wrap_up;
   end
   initial begin : main
      integer k;
      resetn = 1'b0;
      pl = 8'h00;
      wake_cause = 2'h0;
      nwake_cause = 2'h0;
      sys_time = 40'hF0_1234_5678;
      lfsr = 32'hC75C;
      n_fail = 0;
      checks_done = 0;
      repeat (20) @(posedge core_clk);
      resetn <= 1'b1;
      rr(8'h2B);
      chk(q, PID);
      wr(8'h2B, 8'hFF);
      rr(8'h2B);
      chk(q, PID);
      rr(8'h30);
      chk(q, 8'h00);
      for (k = 0; k < 6; k = k + 1) begin
         lfsr = nxt(lfsr);
         w = (k < 3) ? k[1:0] + 2'h1 : ((lfsr[1:0] == 2'h0) ? 2'h3 : lfsr[1:0]);
         n = (k < 3) ? 2'h3 - k[1:0] : ((lfsr[3:2] == 2'h0) ? 2'h1 : lfsr[3:2]);
         wake_cause <= w;
         nwake_cause <= n;
         fire(8'h01, t);
         fire(8'h02, t2);
         chk(host_irq_out_q, 1'b1);
         chk(irq_time_param_q, t);
         ts(t);
         st(stv(1'b1, w, n, 1'b0, 1'b0));
         fire(8'h20, t2);
         st(stv(1'b1, 2'h0, n, 1'b0, 1'b0));
         fire(8'h40, t2);
         st(8'h00);
      end
      wr(8'h06, 8'hF3);
      chk(ctrl_q, 8'h03);
      fire(8'h03, t);
      st(stv(1'b0, w, n, 1'b0, 1'b0));
      fire(8'h60, t);
      wr(8'h06, 8'h00);
      fire(8'h04, t);
      st(stv(1'b1, 2'h0, 2'h0, 1'b1, 1'b0));
      fire(8'h80, t);
      st(8'h00);
      wr(8'h06, 8'h08);
      fire(8'h0C, t);
      st(stv(1'b1, 2'h0, 2'h0, 1'b0, 1'b1));
      fire(8'h80, t2);
      fire(8'h10, t2);
      ts(t);
      wr(8'h06, 8'h04);
      fire(8'h10, t);
      fire(8'h01, t2);
      ts(t);
      chk(irq_time_param_q, t2);
      fire(8'h20, t);
      st(8'h00);
      wrap_up;
   end
endmodule // hists_core_tb
bind hists_core hists_core_chk #(.PRODUCT_ID_VAL(PRODUCT_ID_VAL)) hists_core_chk_inst (
   .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .wake_evt(wake_evt),
   .wake_cause(wake_cause), .rd_wake_chan(rd_wake_chan), .rd_nwake_chan(rd_nwake_chan),
   .rd_status_chan(rd_status_chan), .host_irq_out_q(host_irq_out_q),
   .irq_time_param_q(irq_time_param_q), .ctrl_q(ctrl_q));
